// >>> logic/lucb_bank.sv
// unit configuration bank: index/data access to eight per-unit register banks
// assumes strobes are already decoded from the host port, one cycle each,
// and that cfg_state and soft_rst come from chip-level logic on clk
`timescale 1ns/1ps
module lucb_bank #(
  parameter logic [7:0] BASE_MASK = 8'hEF,
  parameter logic [7:0] BASE2_MASK = 8'h00,
  parameter logic [7:0] DMA_MASK = 8'h03,
  parameter logic [7:0] IRQ_SEC_MASK = 8'h10
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // host port
  input wire logic cfg_state,
  input wire lucb_pkg::lucb_req_s req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // unit power-control strobes
  input wire logic [7:0] pm_set,
  input wire logic [7:0] pm_clr,
  // per-unit configuration
  output logic [7:0] unit_on,
  output logic [7:0] unit_decode_en,
  output logic [7:0][15:0] unit_base,
  output logic [7:0][15:0] unit_base2,
  output logic [7:0][7:0] unit_irq_pri,
  output logic [7:0] kbd_irq_sec,
  output logic [7:0][7:0] unit_dma,
  output logic [7:0] irq_edge_high
);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // a strobe is taken at the rising edge that sees it; read data and its
  // valid pulse stand from that same edge, and a write shows on the unit
  // outputs from that edge too; nothing stalls, so the host may
  // issue one strobe every cycle

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] unit_num;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] edge_high;
    lucb_pkg::lucb_bank_s [lucb_pkg::NUM_BANKS-1:0] bank;
  } lucb_state_s;

  lucb_state_s st;
  lucb_state_s next_st;
  lucb_pkg::lucb_sel_s sel;
  logic [7:0] cfg_set;
  logic [7:0] cfg_clr;
  logic [7:0] base_ok;

  // power-on contents of every bank
  function automatic lucb_state_s reset_state();
    lucb_state_s s;
    s = '0;
    s.edge_high = '1;
    s.bank[lucb_pkg::BANK_FLOPPY].irq_pri = lucb_pkg::IRQ_PRI_RST_FLOPPY;
    // dma defaults of floppy and parallel
    s.bank[lucb_pkg::BANK_FLOPPY].dma = lucb_pkg::DMA_RST_FLOPPY;
    s.bank[lucb_pkg::BANK_PARALLEL].dma = lucb_pkg::DMA_RST_PARALLEL;
    return s;
  endfunction : reset_state

  localparam lucb_state_s RST_STATE = reset_state();

  // ----------------------------------------------------------------
  // register presence
  // ----------------------------------------------------------------
  // one table says which slots a bank implements; the read mux and the
  // write path both ask it, so a slot can never take a write that it
  // would then read back as zero, nor the reverse
  function automatic logic reg_present(input logic [7:0] index, input logic [2:0] b);
    logic p;
    p = 1'b0;
    case (index)
      lucb_pkg::IDX_ACTIVATE: p = 1'b1;
      lucb_pkg::IDX_BASE_HI: p = BASE_MASK[b];
      lucb_pkg::IDX_BASE_LO: p = BASE_MASK[b];
      lucb_pkg::IDX_BASE2_HI: p = BASE2_MASK[b];
      lucb_pkg::IDX_BASE2_LO: p = BASE2_MASK[b];
      lucb_pkg::IDX_IRQ_PRI: p = 1'b1;
      lucb_pkg::IDX_IRQ_SEC: p = IRQ_SEC_MASK[b];
      lucb_pkg::IDX_DMA: p = DMA_MASK[b];
      default: p = 1'b0;
    endcase
    return p;
  endfunction : reg_present

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_value(input lucb_state_s s, input lucb_pkg::lucb_sel_s b,
                                            input logic [7:0] on);
    logic [7:0] v;
    v = lucb_pkg::REG_RST;
    if (s.index == lucb_pkg::IDX_UNIT_NUM) begin
      v = s.unit_num;
    end else if (b.hit && reg_present(s.index, b.idx)) begin
      case (s.index)
        lucb_pkg::IDX_ACTIVATE: v[lucb_pkg::ACT_BIT] = on[b.idx];
        lucb_pkg::IDX_BASE_HI: v = s.bank[b.idx].base[15:8];
        lucb_pkg::IDX_BASE_LO: v = s.bank[b.idx].base[7:0];
        lucb_pkg::IDX_BASE2_HI: v = s.bank[b.idx].base2[15:8];
        lucb_pkg::IDX_BASE2_LO: v = s.bank[b.idx].base2[7:0];
        lucb_pkg::IDX_IRQ_PRI: v = s.bank[b.idx].irq_pri;
        lucb_pkg::IDX_IRQ_SEC: v = s.bank[b.idx].irq_sec;
        lucb_pkg::IDX_DMA: v = s.bank[b.idx].dma;
        default: v = lucb_pkg::REG_RST;
      endcase
    end
    return v;
  endfunction : read_value

  // ----------------------------------------------------------------
  // access sequencing
  // ----------------------------------------------------------------
  // bank chosen by the held unit number
  // unit number is stored, so later accesses stay steered to it
  assign sel = lucb_pkg::bank_of(st.unit_num);

  // ----------------------------------------------------------------
  // strobe qualification
  // ----------------------------------------------------------------
  logic host_live;
  logic take_idx;
  logic take_rd;
  logic take_wr;
  logic take_unit;
  logic take_bank;

  // only in configuration state; a soft reset in the same cycle
  // swallows the strobe, since it rewrites every register anyway
  assign host_live = cfg_state && !soft_rst;
  // one access per cycle: index write beats a read, a read beats a write
  assign take_idx = host_live && req.idx_wr;
  assign take_rd = host_live && !req.idx_wr && req.data_rd;
  assign take_wr = host_live && !req.idx_wr && !req.data_rd && req.data_wr;
  // unit number held outside the banks
  assign take_unit = take_wr && (st.index == lucb_pkg::IDX_UNIT_NUM);
  assign take_bank = take_wr && !take_unit && sel.hit && reg_present(st.index, sel.idx);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the take_ strobes exclude each other, so plain ifs suffice
  always_comb begin
    next_st = st;
    cfg_set = '0;
    cfg_clr = '0;
    next_st.rd_valid = 1'b0;
    if (soft_rst) begin
      next_st = RST_STATE;
    end
    if (take_idx) begin
      next_st.index = req.wdata;
    end
    if (take_rd) begin
      // data read of the chosen register
      next_st.rd_data = read_value(st, sel, unit_on);
      next_st.rd_valid = 1'b1;
    end
    if (take_unit) begin
      next_st.unit_num = req.wdata;
    end
    if (take_bank) begin
      case (st.index)
        lucb_pkg::IDX_ACTIVATE: begin
          cfg_set[sel.idx] = req.wdata[lucb_pkg::ACT_BIT];
          cfg_clr[sel.idx] = ~req.wdata[lucb_pkg::ACT_BIT];
        end
        lucb_pkg::IDX_BASE_HI: next_st.bank[sel.idx].base[15:8] = req.wdata;
        lucb_pkg::IDX_BASE_LO: next_st.bank[sel.idx].base[7:0] = req.wdata;
        lucb_pkg::IDX_BASE2_HI: next_st.bank[sel.idx].base2[15:8] = req.wdata;
        lucb_pkg::IDX_BASE2_LO: next_st.bank[sel.idx].base2[7:0] = req.wdata;
        lucb_pkg::IDX_IRQ_PRI: next_st.bank[sel.idx].irq_pri = req.wdata;
        lucb_pkg::IDX_IRQ_SEC: next_st.bank[sel.idx].irq_sec = req.wdata;
        lucb_pkg::IDX_DMA: next_st.bank[sel.idx].dma = req.wdata;
        default: ;
      endcase
    end
  end

  // all kinds of reset reach this flop set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // coupled activate / power control
  // ----------------------------------------------------------------
  // kept in its own module so the unit runtime logic and the host
  // share one flop and can never see different answers
  lucb_unit_power #(
    .NUM(lucb_pkg::NUM_BANKS)
  ) u_power (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .cfg_set(cfg_set),
    .cfg_clr(cfg_clr),
    .pm_set(pm_set),
    .pm_clr(pm_clr),
    .on(unit_on)
  );

  // ----------------------------------------------------------------
  // per-unit outputs and decode qualification
  // ----------------------------------------------------------------
  // every unit output comes from a flop or a constant, so a unit sees
  // a new setting from the same edge that takes the host write that made it
  genvar g;
  generate
    for (g = 0; g < lucb_pkg::NUM_BANKS; g++) begin : g_unit
      lucb_base_check #(
        .BANK(3'(g))
      ) u_check (
        .base(st.bank[g].base),
        .ok(base_ok[g])
      );
      // keyboard reports its fixed data port, not a register
      assign unit_base[g] = (g == lucb_pkg::BANK_KEYBOARD) ? lucb_pkg::KBD_DATA_ADDR :
                            st.bank[g].base;
      assign unit_base2[g] = (g == lucb_pkg::BANK_KEYBOARD) ? lucb_pkg::KBD_CMD_ADDR :
                             st.bank[g].base2;
      assign unit_irq_pri[g] = st.bank[g].irq_pri;
      assign unit_dma[g] = st.bank[g].dma;
    end
  endgenerate

  // ----------------------------------------------------------------
  // limitations
  // ----------------------------------------------------------------
  // a base outside its window only drops unit_decode_en; the registers
  // stay reachable, so software can still move the unit somewhere legal.
  // no unit but the keyboard, whose second base is the fixed KBD_CMD_ADDR, keeps one unless BASE2_MASK grants one, and that
  // base is passed on unchecked: the window test covers the first only.
  // a unit outside DMA_MASK takes no dma write and reads zero at the dma
  // index, but floppy and parallel still drive their reset default on unit_dma

  // decode only for an active unit whose base is in its window
  assign unit_decode_en = unit_on & base_ok;
  assign kbd_irq_sec = st.bank[lucb_pkg::BANK_KEYBOARD].irq_sec;
  assign irq_edge_high = st.edge_high;
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;

endmodule : lucb_bank

// >>> logic/lucb_base_check.sv
// unit configuration bank: per-unit base window check
// assumes base comes straight from the bank flops, same clock
`timescale 1ns/1ps
module lucb_base_check #(
  parameter logic [2:0] BANK = 3'h0
) (
  // programmed base
  input wire logic [15:0] base,
  // verdict
  output logic ok
);

  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] align;

  // window per unit kind; keyboard is fixed and always passes the check
  always_comb begin
    lo = lucb_pkg::BASE_MIN;
    hi = lucb_pkg::BASE_MAX_8;
    align = lucb_pkg::ALIGN_8;
    case (BANK)
      lucb_pkg::BANK_PARALLEL: begin
        hi = lucb_pkg::BASE_MAX_4;
        align = lucb_pkg::ALIGN_4;
      end
      lucb_pkg::BANK_GAME: begin
        hi = lucb_pkg::BASE_MAX_1;
        align = lucb_pkg::ALIGN_1;
      end
      lucb_pkg::BANK_RUNTIME: begin
        lo = lucb_pkg::RT_BASE_MIN;
        hi = lucb_pkg::RT_BASE_MAX;
        align = lucb_pkg::ALIGN_128;
      end
      lucb_pkg::BANK_MIDI: begin
        hi = lucb_pkg::BASE_MAX_2;
        align = lucb_pkg::ALIGN_2;
      end
      default: ;
    endcase
  end

  assign ok = (BANK == lucb_pkg::BANK_KEYBOARD) ||
              ((base >= lo) && (base <= hi) && ((base & align) == lucb_pkg::ALIGN_1));

endmodule : lucb_base_check

// >>> logic/lucb_pkg.sv
// unit configuration bank: shared constants, carriers and decode helpers
// assumes one 10 MHz clock and a host port already decoded to index/data strobes
package lucb_pkg;

  // ----------------------------------------------------------------
  // bank geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int ACT_BIT = 0;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNIT_NUM = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_PRI = 8'h70;
  localparam logic [7:0] IDX_IRQ_SEC = 8'h72;
  localparam logic [7:0] IDX_DMA = 8'h74;

  // ----------------------------------------------------------------
  // unit numbers and their bank slots
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_FLOPPY = 8'h00;
  localparam logic [7:0] UNIT_PARALLEL = 8'h03;
  localparam logic [7:0] UNIT_SERIAL1 = 8'h04;
  localparam logic [7:0] UNIT_SERIAL2 = 8'h05;
  localparam logic [7:0] UNIT_KEYBOARD = 8'h07;
  localparam logic [7:0] UNIT_GAME = 8'h09;
  localparam logic [7:0] UNIT_RUNTIME = 8'h0A;
  localparam logic [7:0] UNIT_MIDI = 8'h0B;
  localparam logic [2:0] BANK_FLOPPY = 3'h0;
  localparam logic [2:0] BANK_PARALLEL = 3'h1;
  localparam logic [2:0] BANK_SERIAL1 = 3'h2;
  localparam logic [2:0] BANK_SERIAL2 = 3'h3;
  localparam logic [2:0] BANK_KEYBOARD = 3'h4;
  localparam logic [2:0] BANK_GAME = 3'h5;
  localparam logic [2:0] BANK_RUNTIME = 3'h6;
  localparam logic [2:0] BANK_MIDI = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] IRQ_PRI_RST_FLOPPY = 8'h06;
  localparam logic [7:0] DMA_RST_FLOPPY = 8'h02;
  localparam logic [7:0] DMA_RST_PARALLEL = 8'h04;

  // ----------------------------------------------------------------
  // permitted base windows
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX_8 = 16'h0FF8;
  localparam logic [15:0] BASE_MAX_4 = 16'h0FFC;
  localparam logic [15:0] BASE_MAX_2 = 16'h0FFE;
  localparam logic [15:0] BASE_MAX_1 = 16'h0FFF;
  localparam logic [15:0] RT_BASE_MIN = 16'h0000;
  localparam logic [15:0] RT_BASE_MAX = 16'h0F7F;
  localparam logic [15:0] ALIGN_8 = 16'h0007;
  localparam logic [15:0] ALIGN_4 = 16'h0003;
  localparam logic [15:0] ALIGN_2 = 16'h0001;
  localparam logic [15:0] ALIGN_1 = 16'h0000;
  localparam logic [15:0] ALIGN_128 = 16'h007F;
  localparam logic [15:0] KBD_DATA_ADDR = 16'h0060;
  localparam logic [15:0] KBD_CMD_ADDR = 16'h0064;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } lucb_req_s;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] base2;
    logic [7:0] irq_pri;
    logic [7:0] irq_sec;
    logic [7:0] dma;
  } lucb_bank_s;

  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } lucb_sel_s;

  // unit number to bank slot; reserved numbers miss
  function automatic lucb_sel_s bank_of(input logic [7:0] unit);
    lucb_sel_s s;
    s.hit = 1'b1;
    case (unit)
      UNIT_FLOPPY: s.idx = BANK_FLOPPY;
      UNIT_PARALLEL: s.idx = BANK_PARALLEL;
      UNIT_SERIAL1: s.idx = BANK_SERIAL1;
      UNIT_SERIAL2: s.idx = BANK_SERIAL2;
      UNIT_KEYBOARD: s.idx = BANK_KEYBOARD;
      UNIT_GAME: s.idx = BANK_GAME;
      UNIT_RUNTIME: s.idx = BANK_RUNTIME;
      UNIT_MIDI: s.idx = BANK_MIDI;
      default: begin
        s.hit = 1'b0;
        s.idx = BANK_FLOPPY;
      end
    endcase
    return s;
  endfunction : bank_of

endpackage : lucb_pkg

// >>> logic/lucb_unit_power.sv
// unit configuration bank: coupled activate / power-control bits
// assumes set and clear strobes are one-cycle pulses on clk
`timescale 1ns/1ps
module lucb_unit_power #(
  parameter int NUM = 8
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // configuration writes
  input wire logic [NUM-1:0] cfg_set,
  input wire logic [NUM-1:0] cfg_clr,
  // unit power-control writes
  input wire logic [NUM-1:0] pm_set,
  input wire logic [NUM-1:0] pm_clr,
  // coupled bit per unit
  output logic [NUM-1:0] on
);

  typedef struct packed {
    logic [NUM-1:0] on;
  } lucb_pwr_s;

  lucb_pwr_s st;
  lucb_pwr_s next_st;

  // one stored bit serves both controls, so they never disagree
  // unit on whenever that shared bit is set
  always_comb begin
    next_st = st;
    if (soft_rst) begin
      next_st.on = '0;
    end else begin
      // a set on either side wins over a clear in the same cycle
      next_st.on = (st.on & ~(cfg_clr | pm_clr)) | cfg_set | pm_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign on = st.on;

endmodule : lucb_unit_power

// >>> verification/lucb_bank_checker.sv
// unit bank checker: port-level timing and reset relations
// assumes it is bound to lucb_bank and sees only its ports
`timescale 1ns/1ps
module lucb_bank_checker (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // host port
  input wire logic cfg_state,
  input wire lucb_pkg::lucb_req_s req,
  input wire logic rd_valid,
  // power strobes
  input wire logic [7:0] pm_set,
  input wire logic [7:0] pm_clr,
  // unit outputs
  input wire logic [7:0] unit_on,
  input wire logic [7:0] unit_decode_en,
  input wire logic [7:0][15:0] unit_base,
  input wire logic [7:0][15:0] unit_base2,
  input wire logic [7:0][7:0] unit_irq_pri,
  input wire logic [7:0][7:0] unit_dma,
  input wire logic [7:0] irq_edge_high
);
  // ----------------------------------------
  // timing relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read is taken only when no index write beats it
  logic rd_take;
  assign rd_take = cfg_state && req.data_rd && !req.idx_wr && !soft_rst;
  rd_answer_a: assert property (rd_take |=> rd_valid)
    else $error("read not answered in one cycle");
  rd_quiet_a: assert property (!rd_take |=> !rd_valid)
    else $error("answer without a taken read");
  cfg_gate_a: assert property (!cfg_state && pm_set == 8'h00 && pm_clr == 8'h00 && !soft_rst
    |=> $stable(unit_on))
    else $error("unit on changed outside config state");
  edge_high_a: assert property (irq_edge_high == 8'hFF)
    else $error("interrupt polarity not edge high");
  kbd_fixed_a: assert property (unit_base[4] == 16'h0060 && unit_base2[4] == 16'h0064)
    else $error("keyboard base moved");
  decode_on_a: assert property ((unit_decode_en & ~unit_on) == 8'h00)
    else $error("decode enabled on inactive unit");
  pm_set_a: assert property (pm_set[2] && !soft_rst |=> unit_on[2])
    else $error("power set did not set activate");
  pm_clr_a: assert property (pm_clr[2] && !pm_set[2] && !req.data_wr && !soft_rst
    |=> !unit_on[2])
    else $error("power clear did not clear activate");
  soft_clear_a: assert property (soft_rst && pm_set == 8'h00 |=> unit_on == 8'h00
    && unit_irq_pri[0] == 8'h06 && unit_dma[1] == 8'h04)
    else $error("soft reset values wrong");
  dma_only_a: assert property (unit_dma[7:2] == '0)
    else $error("dma select outside floppy and parallel");
endmodule : lucb_bank_checker

bind lucb_bank lucb_bank_checker i_chk (.clk(clk), .rst(rst), .soft_rst(soft_rst),
  .cfg_state(cfg_state), .req(req), .rd_valid(rd_valid), .pm_set(pm_set),
  .pm_clr(pm_clr), .unit_on(unit_on), .unit_decode_en(unit_decode_en),
  .unit_base(unit_base), .unit_base2(unit_base2), .unit_irq_pri(unit_irq_pri),
  .unit_dma(unit_dma), .irq_edge_high(irq_edge_high));

// >>> verification/lucb_host.sv
// host model: index/data port master of the unit bank
// assumes strobes change at the falling edge of clk
`timescale 1ns/1ps
module lucb_host (
  // clock
  input wire logic clk,
  // host port
  output logic cfg_state,
  output lucb_pkg::lucb_req_s req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // ----------------------------------------
  // strobes
  // ----------------------------------------
  // idle until the bench enters config state
  initial begin
    cfg_state = 1'b0;
    req = '0;
  end
  // one strobe for one cycle; answer sampled a cycle on
  task automatic op(input logic [2:0] k, input logic [7:0] d,
                    output logic [7:0] q, output logic v);
    @(negedge clk);
    req = {k, d};
    @(negedge clk);
    req = '0;
    v = rd_valid;
    q = rd_data;
  endtask : op
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    op(3'b100, i, q, v);
    op(3'b010, d, q, v);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [7:0] q, output logic v);
    op(3'b100, i, q, v);
    op(3'b001, 8'h00, q, v);
  endtask : rd
endmodule : lucb_host

// >>> verification/test_logical_unit_config_bank.sv
// bench for the unit bank: host model plus hand-written scenarios
// assumes a 10 MHz clock and the host model on the index/data port
`timescale 1ns/1ps
module test_logical_unit_config_bank;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic cfg_state;
  lucb_pkg::lucb_req_s req;
  logic [7:0] rd_data, pm_set = 8'h00, pm_clr = 8'h00;
  logic rd_valid;
  logic [7:0] unit_on, unit_decode_en, kbd_irq_sec, irq_edge_high;
  logic [7:0][15:0] unit_base, unit_base2;
  logic [7:0][7:0] unit_irq_pri, unit_dma;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] gaps [14] = '{8'h31, 8'h37, 8'h38, 8'h3F, 8'h40, 8'h5F, 8'h71,
    8'h72, 8'h73, 8'h75, 8'h76, 8'hA8, 8'hA9, 8'hDF};
  always #50 clk = ~clk;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  lucb_bank i_dut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .cfg_state(cfg_state),
    .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .pm_set(pm_set), .pm_clr(pm_clr),
    .unit_on(unit_on), .unit_decode_en(unit_decode_en), .unit_base(unit_base),
    .unit_base2(unit_base2), .unit_irq_pri(unit_irq_pri), .kbd_irq_sec(kbd_irq_sec),
    .unit_dma(unit_dma), .irq_edge_high(irq_edge_high));
  lucb_host i_host (.clk(clk), .cfg_state(cfg_state), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // read through the port; valid flag travels with the data
  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    logic v;
    i_host.rd(i, q, v);
    chk({7'h00, v, q}, {8'h01, e});
  endtask : rchk
  task automatic sel(input logic [7:0] u);
    i_host.wr(lucb_pkg::IDX_UNIT_NUM, u);
  endtask : sel
  task automatic pulse(input logic [7:0] s, input logic [7:0] c);
    @(negedge clk);
    pm_set = s;
    pm_clr = c;
    @(negedge clk);
    pm_set = 8'h00;
    pm_clr = 8'h00;
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(unit_irq_pri[0], 16'h0006);
    chk(unit_irq_pri[1], 16'h0000);
    chk({unit_dma[0], unit_dma[1]}, 16'h0204);
    chk({unit_on, irq_edge_high}, 16'h00FF);
    chk(unit_base[0], 16'h0000);
    rchk(8'h70, 8'h06);
    $display("reset values done");
  endtask : t_reset
  task automatic t_base;
    sel(8'h03);
    i_host.wr(8'h60, 8'h03);
    i_host.wr(8'h61, 8'hF8);
    chk(unit_base[1], 16'h03F8);
    rchk(8'h60, 8'h03);
    rchk(8'h61, 8'hF8);
    i_host.wr(8'h62, 8'h12);
    rchk(8'h62, 8'h00);
    chk(unit_base2[1], 16'h0000);
    sel(8'h07);
    i_host.wr(8'h60, 8'h12);
    rchk(8'h60, 8'h00);
    chk(unit_base[4], 16'h0060);
    $display("base bytes done");
  endtask : t_base
  task automatic t_gaps;
    sel(8'h00);
    foreach (gaps[k]) begin
      i_host.wr(gaps[k], 8'hFF);
      rchk(gaps[k], 8'h00);
    end
    $display("reserved indices done");
  endtask : t_gaps
  task automatic t_units;
    sel(8'h07);
    i_host.wr(8'h72, 8'h05);
    rchk(8'h72, 8'h05);
    chk(kbd_irq_sec, 16'h0005);
    sel(8'h05);
    i_host.wr(8'h70, 8'h09);
    rchk(8'h74, 8'h00);
    rchk(8'h70, 8'h09);
    sel(8'h02);
    i_host.wr(8'h70, 8'h0B);
    rchk(8'h70, 8'h00);
    chk({unit_irq_pri[3], unit_irq_pri[0]}, 16'h0906);
    sel(8'h00);
    i_host.wr(8'h74, 8'h03);
    rchk(8'h74, 8'h03);
    $display("unit banks done");
  endtask : t_units
  task automatic t_act;
    logic [7:0] q;
    logic v;
    sel(8'h04);
    i_host.wr(8'h30, 8'h01);
    chk(unit_on, 16'h0004);
    rchk(8'h30, 8'h01);
    i_host.wr(8'h60, 8'h01);
    i_host.wr(8'h61, 8'h00);
    chk(unit_decode_en[2], 16'h0001);
    i_host.wr(8'h61, 8'h04);
    chk(unit_decode_en[2], 16'h0000);
    pulse(8'h00, 8'h04);
    rchk(8'h30, 8'h00);
    pulse(8'h04, 8'h00);
    chk(unit_on, 16'h0004);
    // config state off: writes and reads are not taken
    i_host.cfg_state = 1'b0;
    i_host.wr(8'h30, 8'h00);
    chk(unit_on, 16'h0004);
    i_host.rd(8'h30, q, v);
    chk({15'h0000, v}, 16'h0000);
    i_host.cfg_state = 1'b1;
    $display("activate done");
  endtask : t_act
  task automatic t_soft;
    @(negedge clk);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    chk({unit_on, kbd_irq_sec}, 16'h0000);
    chk(unit_base[1], 16'h0000);
    chk({unit_irq_pri[0], unit_dma[0]}, 16'h0602);
    rchk(8'h70, 8'h06);
    $display("soft reset done");
  endtask : t_soft
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    i_host.cfg_state = 1'b1;
    t_reset();
    t_base();
    t_gaps();
    t_units();
    t_act();
    t_soft();
    complete_run();
  end
  // whole run is a few hundred cycles; 10000 cycles means a hang
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end
endmodule : test_logical_unit_config_bank
